// *** rtl/ccrc_pkg.sv ***
// package: constants and carriers for the config memory crc checker
package ccrc_pkg;
  localparam int CRC_W = 32;
  localparam logic [31:0] CRC_POLY = 32'h04c1_1db7;
  localparam logic [31:0] CRC_INIT = 32'hffff_ffff;
  localparam logic [31:0] EXP_RESET = 32'h0000_0000;
  localparam logic [31:0] SIG_ZERO = 32'h0000_0000;
  localparam int FRAME_CRC_W = 16;
  localparam logic [15:0] FRAME_POLY = 16'h8005;
  localparam logic [15:0] FRAME_INIT = 16'hffff;
  localparam int IR_W = 10;
  localparam logic [9:0] WRITE_EXPECTED_CHECK_INSTR = 10'h015;
  localparam int CELL_ADDR_W = 10;
  localparam int CELL_DEPTH = 1024;

  typedef enum logic [3:0] {
    CCRC_CONFIG = 4'b0001,
    CCRC_USER = 4'b0010,
    CCRC_FAIL = 4'b0100,
    CCRC_IDLE = 4'b1000
  } ccrc_mode_t;

  // configuration stream word
  typedef struct packed {
    logic valid;
    logic is_check;
    logic last;
    logic [15:0] data;
  } ccrc_cfg_word_t;

  // test port controls, already in mclk domain
  typedef struct packed {
    logic tck;
    logic tdi;
    logic shift_dr;
    logic capture_dr;
    logic update_dr;
  } ccrc_jtag_t;
endpackage

// *** rtl/ccrc_checker.sv ***
// module: configuration cell memory crc checker
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Function
// - Each received frame is checked against its embedded check value and loading stops on the first mismatch.
// - At end of configuration the expected 32-bit check value from the stream is held in a storage register.
// - In user mode the check is recomputed repeatedly until a low reconfiguration request resets it.
// - Only configuration cells are covered; memory blocks and io flip-flops are excluded.
// - One 32-bit computation with the IEEE 802 polynomial covers all checked cells.
// - A zero signature drives the error flag 0, a non-zero one drives it 1.
// - The write instruction places the 32-bit storage register between tdi and tdo.
// - The write instruction acts only in user mode.
// - A wrong expected value loaded by the tester raises the error flag without reconfiguration.
// - The user-mode check keeps running after a crc error is found; a frame check error holds the checker in the fail state.
// - The error flag is active high, push-pull, with no open-drain or inversion option.
module ccrc_checker #(
  parameter int DEPTH = ccrc_pkg::CELL_DEPTH,
  parameter int AW = ccrc_pkg::CELL_ADDR_W
) (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // reconfiguration request pin
  input wire logic reconfig_request_n,
  // configuration stream
  input wire ccrc_pkg::ccrc_cfg_word_t cfg_word,
  // test port, synchronous to mclk
  input wire logic [ccrc_pkg::IR_W-1:0] jtag_ir,
  input wire ccrc_pkg::ccrc_jtag_t jtag,
  output logic tdo,
  // status
  output logic config_done,
  output logic config_error,
  output logic crc_error
);
  //////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [1:0] rq_sync;
    logic [4:0] jt_s1;
    logic [4:0] jt_s2;
    logic tck_d;
    ccrc_pkg::ccrc_mode_t mode;
    logic [15:0] frame_crc;
    logic [AW-1:0] waddr;
    logic [AW-1:0] raddr;
    logic exp_phase;
    logic [1:0] exp_half;
    logic [31:0] expected;
    logic [31:0] shift;
    logic [31:0] run_crc;
    logic [31:0] signature;
    logic flag;
    logic tdo;
    logic done;
    logic cfg_err;
  } ccrc_state_t;

  ccrc_state_t s_q;
  ccrc_state_t s_d;
  logic [15:0] cells [DEPTH];
  logic cell_we;

  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] crc16_step(input logic [15:0] c, input logic [15:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 15; i >= 0; i--)
    begin
      r = (r[15] ^ d[i]) ? ((r << 1) ^ ccrc_pkg::FRAME_POLY) : (r << 1);
    end
    return r;
  endfunction

  function automatic logic [31:0] crc32_step(input logic [31:0] c, input logic [15:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 15; i >= 0; i--)
    begin
      r = (r[31] ^ d[i]) ? ((r << 1) ^ ccrc_pkg::CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // cell store: only configuration cells are held here
  always_ff @(posedge mclk)
  begin
    if (cell_we)
    begin
      cells[s_q.waddr] <= cfg_word.data;
    end
  end

  logic [15:0] cell_rd;
  assign cell_rd = cells[s_q.raddr];

  //////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    logic tck_rise;
    logic shift_dr;
    logic cap_dr;
    logic upd_dr;
    logic sel;
    logic [31:0] nxt_crc;
    tck_rise = 1'b0;
    shift_dr = 1'b0;
    cap_dr = 1'b0;
    upd_dr = 1'b0;
    sel = 1'b0;
    nxt_crc = '0;
    s_d = s_q;
    cell_we = 1'b0;
    s_d.rq_sync = {s_q.rq_sync[0], reconfig_request_n};
    s_d.jt_s1 = jtag;
    s_d.jt_s2 = s_q.jt_s1;
    s_d.tck_d = s_q.jt_s2[4];
    tck_rise = s_q.jt_s2[4] & ~s_q.tck_d;
    shift_dr = s_q.jt_s2[2];
    cap_dr = s_q.jt_s2[1];
    upd_dr = s_q.jt_s2[0];
    // instruction honoured only in user mode
    sel = (jtag_ir == ccrc_pkg::WRITE_EXPECTED_CHECK_INSTR) && (s_q.mode == ccrc_pkg::CCRC_USER);
    case (s_q.mode)
      ccrc_pkg::CCRC_CONFIG:
      begin
        if (cfg_word.valid)
        begin
          if (s_q.exp_phase)
          begin
            // expected value arrives as two halves, high first
            if (s_q.exp_half == 2'd0)
            begin
              s_d.expected[31:16] = cfg_word.data;
              s_d.exp_half = 2'd1;
            end
            else
            begin
              s_d.expected[15:0] = cfg_word.data;
              s_d.done = 1'b1;
              s_d.raddr = '0;
              s_d.run_crc = ccrc_pkg::CRC_INIT;
              s_d.mode = ccrc_pkg::CCRC_USER;
            end
          end
          else if (cfg_word.is_check)
          begin
            if (cfg_word.data != s_q.frame_crc)
            begin
              s_d.cfg_err = 1'b1;
              s_d.mode = ccrc_pkg::CCRC_FAIL;
            end
            else
            begin
              s_d.frame_crc = ccrc_pkg::FRAME_INIT;
              s_d.exp_phase = cfg_word.last;
              s_d.exp_half = 2'd0;
            end
          end
          else
          begin
            cell_we = 1'b1;
            s_d.waddr = s_q.waddr + AW'(1);
            s_d.frame_crc = crc16_step(s_q.frame_crc, cfg_word.data);
          end
        end
      end
      ccrc_pkg::CCRC_USER:
      begin
        // background pass, continues regardless of the flag
        nxt_crc = crc32_step(s_q.run_crc, cell_rd);
        if (s_q.raddr == s_q.waddr - AW'(1))
        begin
          // signature: residue against stored value, zero when intact
          s_d.signature = nxt_crc ^ s_q.expected;
          s_d.flag = (s_d.signature != ccrc_pkg::SIG_ZERO);
          s_d.raddr = '0;
          s_d.run_crc = ccrc_pkg::CRC_INIT;
        end
        else
        begin
          s_d.raddr = s_q.raddr + AW'(1);
          s_d.run_crc = nxt_crc;
        end
        // storage register on the scan path
        if (sel && tck_rise)
        begin
          if (cap_dr)
          begin
            s_d.shift = s_q.expected;
          end
          else if (shift_dr)
          begin
            s_d.tdo = s_q.shift[0];
            s_d.shift = {s_q.jt_s2[3], s_q.shift[31:1]};
          end
          else if (upd_dr)
          begin
            s_d.expected = s_q.shift;
          end
        end
      end
      ccrc_pkg::CCRC_FAIL:
      begin
        s_d.mode = ccrc_pkg::CCRC_FAIL;
      end
      default:
      begin
        s_d.mode = ccrc_pkg::CCRC_CONFIG;
      end
    endcase
    // low request restarts configuration
    if (!s_q.rq_sync[1])
    begin
      s_d.mode = ccrc_pkg::CCRC_CONFIG;
      s_d.frame_crc = ccrc_pkg::FRAME_INIT;
      s_d.waddr = '0;
      s_d.raddr = '0;
      s_d.exp_phase = 1'b0;
      s_d.exp_half = 2'd0;
      s_d.done = 1'b0;
      s_d.cfg_err = 1'b0;
      s_d.flag = 1'b0;
      s_d.signature = ccrc_pkg::SIG_ZERO;
      cell_we = 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      s_q <= '0;
      s_q.rq_sync <= 2'b11;
      s_q.mode <= ccrc_pkg::CCRC_CONFIG;
      s_q.frame_crc <= ccrc_pkg::FRAME_INIT;
      s_q.expected <= ccrc_pkg::EXP_RESET;
      s_q.run_crc <= ccrc_pkg::CRC_INIT;
      s_q.signature <= ccrc_pkg::SIG_ZERO;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // push-pull active-high flag straight from a flop
  assign crc_error = s_q.flag;
  assign tdo = s_q.tdo;
  assign config_done = s_q.done;
  assign config_error = s_q.cfg_err;
endmodule

// *** tb/ccrc_tester.sv ***
// partner: jtag tester that scans the storage register
`timescale 1ns/1ps
module ccrc_tester (
  // clock
  input wire logic mclk,
  // scan lines
  input wire logic tdo,
  output ccrc_pkg::ccrc_jtag_t jtag
);
  initial jtag = '0;
  ////////////////////////////////////////////////////////////////////////////
  // one slow tck period, 4 mclk a phase
  task automatic tick;
    repeat (4) @(posedge mclk);
    #1 jtag.tck = 1'h1;
    repeat (4) @(posedge mclk);
    #1 jtag.tck = 1'h0;
  endtask
  // capture, 32 shifts lsb first, update
  task automatic scan(input logic [31:0] din, output logic [31:0] dout);
    jtag.capture_dr = 1'h1;
    tick();
    jtag.capture_dr = 1'h0;
    jtag.shift_dr = 1'h1;
    for (int i = 0; i < 32; i++)
    begin
      jtag.tdi = din[i];
      tick();
      dout[i] = tdo;
    end
    jtag.shift_dr = 1'h0;
    jtag.update_dr = 1'h1;
    tick();
    jtag.update_dr = 1'h0;
  endtask
endmodule

// *** tb/ccrc_checker_properties.sv ***
// checker: port properties of the crc checker
`timescale 1ns/1ps
module ccrc_props #(
  parameter int DEPTH = ccrc_pkg::CELL_DEPTH
) (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // inputs
  input wire logic reconfig_request_n,
  input wire ccrc_pkg::ccrc_cfg_word_t cfg_word,
  input wire logic [ccrc_pkg::IR_W-1:0] jtag_ir,
  // outputs
  input wire logic tdo,
  input wire logic config_done,
  input wire logic config_error,
  input wire logic crc_error
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  property p_excl; !(config_done && config_error); endproperty
  a_excl: assert property (p_excl)
    else $error("done with error");
  property p_err; config_error && reconfig_request_n |=> config_error; endproperty
  a_err: assert property (p_err)
    else $error("error dropped");
  property p_done; config_done && reconfig_request_n |=> config_done; endproperty
  a_done: assert property (p_done)
    else $error("done dropped");
  property p_dsrc; $rose(config_done) |-> $past(cfg_word.valid); endproperty
  a_dsrc: assert property (p_dsrc)
    else $error("done without word");
  property p_esrc; $rose(config_error) |-> $past(cfg_word.is_check); endproperty
  a_esrc: assert property (p_esrc)
    else $error("error without check");
  property p_quiet; !config_done && !crc_error |=> !crc_error; endproperty
  a_quiet: assert property (p_quiet)
    else $error("flag outside user mode");
  property p_pass; $changed(crc_error) |=> $stable(crc_error)[*3]; endproperty
  a_pass: assert property (p_pass)
    else $error("flag changed mid pass");
  property p_tdo;
    (jtag_ir != ccrc_pkg::WRITE_EXPECTED_CHECK_INSTR) || !config_done |=> $stable(tdo);
  endproperty
  a_tdo: assert property (p_tdo)
    else $error("scan with other instr");
endmodule
bind ccrc_checker ccrc_props #(.DEPTH(DEPTH)) u_props (.mclk(mclk), .resetn(resetn),
  .reconfig_request_n(reconfig_request_n), .cfg_word(cfg_word), .jtag_ir(jtag_ir),
  .tdo(tdo), .config_done(config_done), .config_error(config_error), .crc_error(crc_error));

// *** tb/config_memory_crc_checker_tb.sv ***
// bench: configuration, injection and reconfiguration
`timescale 1ns/1ps
module config_memory_crc_checker_tb;
  logic mclk, resetn, req_n, tdo, done, cerr, crc_err;
  logic [ccrc_pkg::IR_W-1:0] ir;
  ccrc_pkg::ccrc_cfg_word_t cw;
  ccrc_pkg::ccrc_jtag_t jt;
  int bad_count, samples_checked;
  logic [15:0] cells [4];
  logic [31:0] exp_crc, rd;
  ccrc_checker #(.DEPTH(4), .AW(2)) DUT (.mclk(mclk), .resetn(resetn),
    .reconfig_request_n(req_n), .cfg_word(cw), .jtag_ir(ir), .jtag(jt), .tdo(tdo),
    .config_done(done), .config_error(cerr), .crc_error(crc_err));
  ccrc_tester tester (.mclk(mclk), .tdo(tdo), .jtag(jt));
  initial
  begin
    mclk = 1'h0;
    forever #25 mclk = ~mclk;
  end
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] crc(logic [31:0] c, logic [31:0] p, int w, logic [15:0] d);
    for (int i = 15; i >= 0; i--)
      c = (c[w-1] ^ d[i]) ? ((c << 1) ^ p) : (c << 1);
    return c;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      $display("MISMATCH %0t got %h want %h", $time, got, exp);
      bad_count++;
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic await(input logic on_err);
    for (int n = 0; (on_err ? cerr : done) !== 1'h1; n++)
    begin
      if (n == 20)
      begin
        $display("MISMATCH %0t wait timed out", $time);
        bad_count++;
        test_done();
      end
      cyc(1);
    end
  endtask
  task automatic send(input logic c, input logic l, input logic [15:0] d);
    cw = '{1'h1, c, l, d};
    cyc(1);
  endtask
  task automatic load(input logic bad);
    logic [15:0] f;
    f = ccrc_pkg::FRAME_INIT;
    for (int i = 0; i < 4; i++)
    begin
      send(1'h0, 1'h0, cells[i]);
      f = 16'(crc({16'h0, f}, {16'h0, ccrc_pkg::FRAME_POLY}, 16, cells[i]));
    end
    send(1'h1, 1'h1, f ^ {15'h0, bad});
    send(1'h0, 1'h0, exp_crc[31:16]);
    send(1'h0, 1'h0, exp_crc[15:0]);
    cw = '0;
  endtask
  task automatic reconf;
    req_n = 1'h0;
    cyc(6);
    req_n = 1'h1;
    cyc(3);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_config;
    load(1'h0);
    await(1'h0);
    chk(32'(cerr), 32'h0);
    cyc(12);
    chk(32'(crc_err), 32'h0);
    tester.scan(exp_crc, rd);
    chk(rd, exp_crc);
    ir = ~ccrc_pkg::WRITE_EXPECTED_CHECK_INSTR;
    tester.scan(~exp_crc, rd);
    chk(rd, {32{exp_crc[31]}});
    ir = ccrc_pkg::WRITE_EXPECTED_CHECK_INSTR;
  endtask
  task automatic t_inject;
    tester.scan(~exp_crc, rd);
    chk(rd, exp_crc);
    cyc(12);
    chk(32'(crc_err), 32'h1);
    cyc(12);
    chk(32'(crc_err), 32'h1);
    tester.scan(exp_crc, rd);
    chk(rd, ~exp_crc);
    cyc(12);
    chk(32'(crc_err), 32'h0);
  endtask
  task automatic t_bad_frame;
    reconf();
    chk(32'(done), 32'h0);
    tester.scan(~exp_crc, rd);
    chk(rd, {32{~exp_crc[31]}});
    load(1'h1);
    await(1'h1);
    chk(32'(cerr), 32'h1);
    chk(32'(done), 32'h0);
    reconf();
    load(1'h0);
    await(1'h0);
    chk(32'(cerr), 32'h0);
    cyc(12);
    chk(32'(crc_err), 32'h0);
  endtask
  initial
  begin
    bad_count = 0;
    samples_checked = 0;
    resetn = 1'h0;
    req_n = 1'h1;
    ir = ccrc_pkg::WRITE_EXPECTED_CHECK_INSTR;
    cw = '0;
    cells = '{16'h1234, 16'hbeef, 16'h0000, 16'ha5c3};
    exp_crc = ccrc_pkg::CRC_INIT;
    foreach (cells[i])
      exp_crc = crc(exp_crc, ccrc_pkg::CRC_POLY, 32, cells[i]);
    cyc(4);
    resetn = 1'h1;
    cyc(3);
    t_config();
    t_inject();
    t_bad_frame();
    test_done();
  end
endmodule
